// ### design/csm_pkg.sv
package csm_pkg;
	localparam int XLEN = 32;
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam logic [4:0] MODE_SYS = 5'h1f;
	localparam logic [31:0] VEC_RESET = 32'h00000000;
	localparam logic [31:0] VEC_UND = 32'h00000004;
	localparam logic [31:0] VEC_SWI = 32'h00000008;
	localparam logic [31:0] VEC_PABT = 32'h0000000c;
	localparam logic [31:0] VEC_DABT = 32'h00000010;
	localparam logic [31:0] VEC_IRQ = 32'h00000018;
	localparam logic [31:0] VEC_FIQ = 32'h0000001c;
	localparam logic [31:0] STEP_NATIVE = 32'h00000004;
	localparam logic [31:0] STEP_COMPACT = 32'h00000002;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] FETCH_WORD_MASK = 2'h3;
	localparam logic [1:0] FETCH_HALF_MASK = 2'h1;
	localparam logic [1:0] BC_DEC_CYCLES = 2'h2;
	typedef enum logic [2:0] {
		CSM_NATIVE = 3'b001,
		CSM_COMPACT = 3'b010,
		CSM_BYTECODE = 3'b100
	} csm_state_type;
	// decoded instruction as seen by the control block
	typedef struct packed {
		logic valid;
		logic bx;
		logic branch_link_exchange;
		logic ld_pc;
		logic branch_to_bytecode;
		logic to_compact;
		logic msr_mode;
		logic [4:0] new_mode;
		logic exc_return;
		logic rd_we;
		logic [3:0] rd;
		logic [3:0] rs1;
		logic [3:0] rs2;
		logic is_load;
		logic bc_complex;
	} csm_dec_type;
	typedef struct packed {
		logic dabt;
		logic fiq;
		logic irq;
		logic pabt;
		logic breakpoint_instruction;
		logic undef;
		logic software_interrupt_trap;
	} csm_exc_type;
	typedef struct packed {
		logic [4:0] mode;
		logic jbit;
		logic tbit;
	} csm_psr_type;
	typedef enum logic [1:0] {
		FWD_NONE = 2'h0,
		FWD_EX = 2'h1,
		FWD_MEM = 2'h2
	} csm_fwd_type;
endpackage

// ### design/csm_core_ctrl.sv
`timescale 1ns/1ps
module csm_core_ctrl #(
	parameter int AW = 32,
	parameter int EXP_LEN = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// decode and exception inputs
	input wire csm_pkg::csm_dec_type dec_i,
	input wire csm_pkg::csm_exc_type exc_i,
	input wire logic [AW-1:0] branch_tgt_i,
	// data access request from execute
	input wire logic dreq_i,
	input wire logic [AW-1:0] daddr_i,
	input wire logic [1:0] dsize_i,
	// bus masters
	output logic iahb_req_o,
	output logic [AW-1:0] iahb_addr_o,
	output logic [1:0] iahb_size_o,
	input wire logic iahb_ready_i,
	output logic dahb_req_o,
	output logic [AW-1:0] dahb_addr_o,
	output logic [1:0] dahb_size_o,
	input wire logic dahb_ready_i,
	// status and pipeline control
	output csm_pkg::csm_state_type state_o,
	output csm_pkg::csm_psr_type cur_psr_o,
	output csm_pkg::csm_psr_type saved_psr_o,
	output logic privileged_o,
	output logic stall_o,
	output csm_pkg::csm_fwd_type fwd_a_o,
	output csm_pkg::csm_fwd_type fwd_b_o,
	output logic align_fault_o,
	output logic [4:0] stage_valid_o,
	output logic expanding_o
);
	csm_pkg::csm_state_type state_r, state_nxt;
	csm_pkg::csm_psr_type cur_r, cur_nxt;
	csm_pkg::csm_psr_type saved_r [7];
	logic [AW-1:0] pc_r, pc_nxt;
	logic dec2_r;
	logic [4:0] stg_r;
	logic ex_we_r, mem_we_r, ex_ld_r;
	logic [3:0] ex_rd_r, mem_rd_r;
	logic [$clog2(EXP_LEN+1)-1:0] exp_cnt_r;
	logic [1:0] dsize_r;
	logic [AW-1:0] daddr_r;
	logic dreq_r;

	// exception selection, priority order fixed in hardware
	wire logic take_dabt = exc_i.dabt;
	wire logic fiq_ok = exc_i.fiq && !take_dabt;
	wire logic irq_ok = exc_i.irq && !take_dabt && !exc_i.fiq;
	wire logic pabt_ok = exc_i.pabt && !take_dabt && !exc_i.fiq && !exc_i.irq;
	wire logic sync_ok = !take_dabt && !exc_i.fiq && !exc_i.irq && !exc_i.pabt;
	wire logic breakpoint_instruction_ok = sync_ok && exc_i.breakpoint_instruction;
	wire logic und_ok = sync_ok && exc_i.undef;
	wire logic swi_ok = sync_ok && exc_i.software_interrupt_trap;
	wire logic exc_take = take_dabt || fiq_ok || irq_ok || pabt_ok || breakpoint_instruction_ok || und_ok || swi_ok;
	wire logic [4:0] exc_mode = (take_dabt || pabt_ok || breakpoint_instruction_ok) ? csm_pkg::MODE_ABT :
		fiq_ok ? csm_pkg::MODE_FIQ :
		irq_ok ? csm_pkg::MODE_IRQ :
		und_ok ? csm_pkg::MODE_UND : csm_pkg::MODE_SVC;
	wire logic [AW-1:0] exc_vec = AW'(take_dabt ? csm_pkg::VEC_DABT :
		fiq_ok ? csm_pkg::VEC_FIQ :
		irq_ok ? csm_pkg::VEC_IRQ :
		(pabt_ok || breakpoint_instruction_ok) ? csm_pkg::VEC_PABT :
		und_ok ? csm_pkg::VEC_UND : csm_pkg::VEC_SWI);

	function automatic logic [2:0] mode_idx(input logic [4:0] m);
		case (m)
			csm_pkg::MODE_FIQ: mode_idx = 3'h1;
			csm_pkg::MODE_IRQ: mode_idx = 3'h2;
			csm_pkg::MODE_SVC: mode_idx = 3'h3;
			csm_pkg::MODE_ABT: mode_idx = 3'h4;
			csm_pkg::MODE_UND: mode_idx = 3'h5;
			default: mode_idx = 3'h0;
		endcase
	endfunction

	// hazards: load-use stalls, alu results forward
	wire logic hit_ex_a = ex_we_r && dec_i.valid && ex_rd_r == dec_i.rs1;
	wire logic hit_ex_b = ex_we_r && dec_i.valid && ex_rd_r == dec_i.rs2;
	wire logic hit_mem_a = mem_we_r && dec_i.valid && mem_rd_r == dec_i.rs1;
	wire logic hit_mem_b = mem_we_r && dec_i.valid && mem_rd_r == dec_i.rs2;
	wire logic load_use = ex_ld_r && (hit_ex_a || hit_ex_b);
	wire logic bus_wait = (iahb_req_o && !iahb_ready_i) || (dahb_req_o && !dahb_ready_i);
	// second bytecode decode cycle holds fetch for one slot
	wire logic bc_hold = state_r == csm_pkg::CSM_BYTECODE && !dec2_r && dec_i.valid;
	wire logic expanding = exp_cnt_r != '0;
	wire logic stall = load_use || bus_wait || bc_hold || expanding;
	wire logic adv = dec_i.valid && !stall;

	// size check against address low bits
	wire logic misalign = dreq_i && ((dsize_i == csm_pkg::SIZE_WORD && |daddr_i[1:0]) ||
		(dsize_i == csm_pkg::SIZE_HALF && daddr_i[0]));
	wire logic bad_size = dreq_i && dsize_i != csm_pkg::SIZE_BYTE &&
		dsize_i != csm_pkg::SIZE_HALF && dsize_i != csm_pkg::SIZE_WORD;

	// restored state from the saved word on return
	wire csm_pkg::csm_psr_type ret_psr = saved_r[mode_idx(cur_r.mode)];
	wire logic priv = cur_r.mode != csm_pkg::MODE_USR;

	always_comb begin
		state_nxt = state_r;
		cur_nxt = cur_r;
		pc_nxt = pc_r;
		if (exc_take) begin
			state_nxt = csm_pkg::CSM_NATIVE;
			cur_nxt.mode = exc_mode;
			cur_nxt.tbit = 1'b0;
			cur_nxt.jbit = 1'b0;
			pc_nxt = exc_vec;
		end else if (adv) begin
			case (state_r)
				csm_pkg::CSM_NATIVE: pc_nxt = pc_r + AW'(csm_pkg::STEP_NATIVE);
				csm_pkg::CSM_COMPACT: pc_nxt = pc_r + AW'(csm_pkg::STEP_COMPACT);
				csm_pkg::CSM_BYTECODE: pc_nxt = pc_r + AW'(csm_pkg::STEP_NATIVE);
				default: pc_nxt = pc_r;
			endcase
			if (dec_i.exc_return && priv) begin
				cur_nxt = ret_psr;
				state_nxt = ret_psr.jbit ? csm_pkg::CSM_BYTECODE :
					ret_psr.tbit ? csm_pkg::CSM_COMPACT : csm_pkg::CSM_NATIVE;
				pc_nxt = branch_tgt_i;
			end else if (dec_i.branch_to_bytecode && state_r == csm_pkg::CSM_NATIVE) begin
				state_nxt = csm_pkg::CSM_BYTECODE;
				cur_nxt.jbit = 1'b1;
				pc_nxt = branch_tgt_i;
			end else if ((dec_i.bx || dec_i.branch_link_exchange || dec_i.ld_pc) &&
				state_r != csm_pkg::CSM_BYTECODE) begin
				state_nxt = dec_i.to_compact ? csm_pkg::CSM_COMPACT : csm_pkg::CSM_NATIVE;
				cur_nxt.tbit = dec_i.to_compact;
				pc_nxt = branch_tgt_i;
			end else if ((dec_i.bx || dec_i.ld_pc) && state_r == csm_pkg::CSM_BYTECODE) begin
				// bytecode leaves only for native
				state_nxt = csm_pkg::CSM_NATIVE;
				cur_nxt.jbit = 1'b0;
				pc_nxt = branch_tgt_i;
			end
			if (dec_i.msr_mode && priv) begin
				cur_nxt.mode = dec_i.new_mode;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= csm_pkg::CSM_NATIVE;
			cur_r <= '{mode: csm_pkg::MODE_SVC, jbit: 1'b0, tbit: 1'b0};
			pc_r <= AW'(csm_pkg::VEC_RESET);
		end else begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			pc_r <= pc_nxt;
		end
	end

	// saved status word per privileged mode, user/system share none
	genvar gi;
	generate
		// slots 0 and 6 never match an exception mode and stay cleared
		for (gi = 0; gi < 7; gi++) begin : g_saved
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					saved_r[gi] <= '0;
				end else if (exc_take && mode_idx(exc_mode) == 3'(gi)) begin
					saved_r[gi] <= cur_r;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dec2_r <= 1'b0;
			exp_cnt_r <= '0;
		end else begin
			dec2_r <= bc_hold;
			if (expanding) begin
				exp_cnt_r <= exp_cnt_r - 1'b1;
			end else if (adv && state_r == csm_pkg::CSM_BYTECODE && dec_i.bc_complex) begin
				exp_cnt_r <= ($clog2(EXP_LEN+1))'(EXP_LEN);
			end
		end
	end

	// pipeline occupancy and write tracking, same registers in all states
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stg_r <= '0;
			ex_we_r <= 1'b0;
			ex_ld_r <= 1'b0;
			ex_rd_r <= '0;
			mem_we_r <= 1'b0;
			mem_rd_r <= '0;
		end else begin
			stg_r <= {stg_r[3:2], adv && !exc_take, !stall, 1'b1};
			ex_we_r <= adv && !exc_take && dec_i.rd_we;
			ex_ld_r <= adv && !exc_take && dec_i.is_load;
			ex_rd_r <= dec_i.rd;
			mem_we_r <= ex_we_r;
			mem_rd_r <= ex_rd_r;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dreq_r <= 1'b0;
			daddr_r <= '0;
			dsize_r <= csm_pkg::SIZE_WORD;
		end else if (!(dahb_req_o && !dahb_ready_i)) begin
			dreq_r <= dreq_i && !misalign && !bad_size;
			daddr_r <= daddr_i;
			dsize_r <= dsize_i;
		end
	end

	// independent masters; data holds until its ready, fetch address moves on an exception even while waiting
	assign iahb_req_o = !expanding;
	assign iahb_addr_o = state_r == csm_pkg::CSM_COMPACT ?
		{pc_r[AW-1:1], 1'b0} : {pc_r[AW-1:2], 2'h0};
	assign iahb_size_o = state_r == csm_pkg::CSM_COMPACT ? csm_pkg::SIZE_HALF :
		csm_pkg::SIZE_WORD;
	assign dahb_req_o = dreq_r;
	assign dahb_addr_o = daddr_r;
	assign dahb_size_o = dsize_r;
	assign state_o = state_r;
	assign cur_psr_o = cur_r;
	assign saved_psr_o = ret_psr;
	assign privileged_o = priv;
	assign stall_o = stall;
	assign fwd_a_o = hit_ex_a && !ex_ld_r ? csm_pkg::FWD_EX :
		hit_mem_a ? csm_pkg::FWD_MEM : csm_pkg::FWD_NONE;
	assign fwd_b_o = hit_ex_b && !ex_ld_r ? csm_pkg::FWD_EX :
		hit_mem_b ? csm_pkg::FWD_MEM : csm_pkg::FWD_NONE;
	assign align_fault_o = misalign || bad_size;
	assign stage_valid_o = stg_r;
	assign expanding_o = expanding;

	a_exc_native: assert property (@(posedge clk_i) disable iff (!nrst_i)
		exc_take |=> state_r == csm_pkg::CSM_NATIVE && !cur_r.tbit && !cur_r.jbit)
		else $error("exception did not enter native state");
	a_abort_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
		exc_i.dabt |=> cur_r.mode == csm_pkg::MODE_ABT)
		else $error("data abort did not enter abort mode");
	a_undef_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
		und_ok |=> cur_r.mode == csm_pkg::MODE_UND)
		else $error("undefined did not enter undefined mode");
	a_saved_word: assert property (@(posedge clk_i) disable iff (!nrst_i)
		exc_take |=> saved_psr_o == $past(cur_r))
		else $error("status word not saved on entry");
	a_fiq_over_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
		exc_i.fiq && exc_i.irq && !exc_i.dabt |=> cur_r.mode == csm_pkg::MODE_FIQ)
		else $error("priority order broken");
	a_bc_word_fetch: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_r == csm_pkg::CSM_BYTECODE |-> iahb_addr_o[1:0] == 2'h0 &&
		iahb_size_o == csm_pkg::SIZE_WORD)
		else $error("bytecode fetch not whole word");
	a_no_misalign: assert property (@(posedge clk_i) disable iff (!nrst_i)
		misalign && !(dahb_req_o && !dahb_ready_i) |=> !dahb_req_o)
		else $error("misaligned access reached bus");
	a_load_use: assert property (@(posedge clk_i) disable iff (!nrst_i)
		load_use && !exc_take |-> stall_o ##1 pc_r == $past(pc_r))
		else $error("load-use hazard not stalled");
	a_bc_enter: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(state_r == csm_pkg::CSM_BYTECODE) |-> $past(dec_i.branch_to_bytecode) || $past(dec_i.exc_return))
		else $error("bytecode entered without branch-to-bytecode");
	a_priv_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!privileged_o && dec_i.msr_mode && adv && !exc_take |=>
		cur_r.mode == $past(cur_r.mode))
		else $error("user mode changed its own mode");
endmodule

// ### bench/csm_ahb_slave.sv
`timescale 1ns/1ps
// answers a transfer after wait_i stalled cycles; ready stays low while idle
module csm_ahb_slave (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// master side
	input wire logic req_i,
	input wire logic [1:0] wait_i,
	output logic ready_o
);
	logic [1:0] cnt_r;
	assign ready_o = req_i && (cnt_r == wait_i);
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= 2'h0;
		end else if (!req_i || ready_o) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end
endmodule

// ### bench/cpu_state_mode_pipeline_test.sv
`timescale 1ns/1ps
module cpu_state_mode_pipeline_test;
	logic clk_i;
	logic nrst_i;
	csm_pkg::csm_dec_type dec_i;
	csm_pkg::csm_dec_type d;
	csm_pkg::csm_exc_type exc_i;
	logic [31:0] branch_tgt_i;
	logic dreq_i;
	logic [31:0] daddr_i;
	logic [1:0] dsize_i;
	logic iahb_req_o;
	logic [31:0] iahb_addr_o;
	logic [1:0] iahb_size_o;
	logic iahb_ready_i;
	logic dahb_req_o;
	logic [31:0] dahb_addr_o;
	logic [1:0] dahb_size_o;
	logic dahb_ready_i;
	logic [1:0] d_wait;
	csm_pkg::csm_state_type state_o;
	csm_pkg::csm_psr_type cur_psr_o;
	csm_pkg::csm_psr_type saved_psr_o;
	logic privileged_o;
	logic stall_o;
	csm_pkg::csm_fwd_type fwd_a_o;
	csm_pkg::csm_fwd_type fwd_b_o;
	logic align_fault_o;
	logic [4:0] stage_valid_o;
	logic expanding_o;
	int error_cnt;
	int checks;
	int n;

	csm_core_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .dec_i(dec_i), .exc_i(exc_i),
		.branch_tgt_i(branch_tgt_i), .dreq_i(dreq_i), .daddr_i(daddr_i), .dsize_i(dsize_i),
		.iahb_req_o(iahb_req_o), .iahb_addr_o(iahb_addr_o), .iahb_size_o(iahb_size_o),
		.iahb_ready_i(iahb_ready_i), .dahb_req_o(dahb_req_o), .dahb_addr_o(dahb_addr_o),
		.dahb_size_o(dahb_size_o), .dahb_ready_i(dahb_ready_i), .state_o(state_o),
		.cur_psr_o(cur_psr_o), .saved_psr_o(saved_psr_o), .privileged_o(privileged_o),
		.stall_o(stall_o), .fwd_a_o(fwd_a_o), .fwd_b_o(fwd_b_o),
		.align_fault_o(align_fault_o), .stage_valid_o(stage_valid_o),
		.expanding_o(expanding_o));
	csm_ahb_slave imem (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(iahb_req_o), .wait_i(2'h0),
		.ready_o(iahb_ready_i));
	csm_ahb_slave dmem (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(dahb_req_o), .wait_i(d_wait),
		.ready_o(dahb_ready_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic do_reset();
		nrst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		nrst_i = 1'b1;
	endtask

	// holds d until taken; n counts the decode cycles it occupied
	task automatic issue();
		@(negedge clk_i);
		dec_i = d;
		#1;
		n = 1;
		while (stall_o !== 1'b0 && n < 6) begin
			@(negedge clk_i);
			#1;
			n++;
		end
		if (stall_o !== 1'b0) begin
			$display("Error issue stall expected 0 seen %b", stall_o);
			error_cnt++;
			finish_test();
		end
		@(negedge clk_i);
		dec_i = '0;
		d = '0;
	endtask

	task automatic exc(input logic [6:0] e);
		@(negedge clk_i);
		exc_i = e;
		@(negedge clk_i);
		exc_i = '0;
	endtask

	task automatic exc_case(input logic [6:0] e, input logic [4:0] m, input logic [31:0] v);
		do_reset();
		exc(e);
		chk("mode", m, cur_psr_o.mode);
		chk("vector", v, iahb_addr_o);
	endtask

	task automatic t_reset();
		do_reset();
		chk("state", csm_pkg::CSM_NATIVE, state_o);
		chk("mode", csm_pkg::MODE_SVC, cur_psr_o.mode);
		chk("fetch addr", csm_pkg::VEC_RESET, iahb_addr_o);
		chk("dahb req", 0, dahb_req_o);
		chk("privileged", 1, privileged_o);
	endtask

	task automatic t_bytecode();
		do_reset();
		d.valid = 1'b1;
		d.branch_to_bytecode = 1'b1;
		issue();
		chk("state", csm_pkg::CSM_BYTECODE, state_o);
		chk("fetch align", 0, iahb_addr_o[1:0]);
		chk("fetch size", csm_pkg::SIZE_WORD, iahb_size_o);
		d.valid = 1'b1;
		issue();
		chk("decode cycles", 2, n);
		exc(7'h10);
		chk("state", csm_pkg::CSM_NATIVE, state_o);
		chk("mode", csm_pkg::MODE_IRQ, cur_psr_o.mode);
		chk("vector", csm_pkg::VEC_IRQ, iahb_addr_o);
		chk("saved", {csm_pkg::MODE_SVC, 2'b10}, saved_psr_o);
		d.valid = 1'b1;
		d.exc_return = 1'b1;
		issue();
		chk("state", csm_pkg::CSM_BYTECODE, state_o);
		d.valid = 1'b1;
		d.bc_complex = 1'b1;
		issue();
		chk("expanding", 1, expanding_o);
		chk("fetch req", 0, iahb_req_o);
		n = 0;
		while (expanding_o === 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		chk("expansion cycles", 4, n);
	endtask

	task automatic t_compact();
		do_reset();
		branch_tgt_i = 32'h00000200;
		d.valid = 1'b1;
		d.bx = 1'b1;
		d.to_compact = 1'b1;
		issue();
		chk("state", csm_pkg::CSM_COMPACT, state_o);
		chk("fetch size", csm_pkg::SIZE_HALF, iahb_size_o);
		exc(7'h02);
		chk("state", csm_pkg::CSM_NATIVE, state_o);
		chk("saved", {csm_pkg::MODE_SVC, 2'b01}, saved_psr_o);
		d.valid = 1'b1;
		d.exc_return = 1'b1;
		issue();
		chk("state", csm_pkg::CSM_COMPACT, state_o);
		d.valid = 1'b1;
		d.ld_pc = 1'b1;
		issue();
		chk("state", csm_pkg::CSM_NATIVE, state_o);
	endtask

	task automatic t_mode();
		do_reset();
		d.valid = 1'b1;
		d.msr_mode = 1'b1;
		d.new_mode = csm_pkg::MODE_USR;
		issue();
		chk("mode", csm_pkg::MODE_USR, cur_psr_o.mode);
		chk("privileged", 0, privileged_o);
		d.valid = 1'b1;
		d.msr_mode = 1'b1;
		d.new_mode = csm_pkg::MODE_SVC;
		issue();
		chk("mode", csm_pkg::MODE_USR, cur_psr_o.mode);
		exc(7'h01);
		chk("mode", csm_pkg::MODE_SVC, cur_psr_o.mode);
		chk("privileged", 1, privileged_o);
	endtask

	task automatic t_hazard();
		do_reset();
		@(negedge clk_i);
		dec_i = '{valid: 1'b1, rd_we: 1'b1, rd: 4'h3, default: '0};
		@(negedge clk_i);
		dec_i = '{valid: 1'b1, rs1: 4'h3, rs2: 4'h3, default: '0};
		#1;
		chk("stall", 0, stall_o);
		chk("hazard a", csm_pkg::FWD_EX, fwd_a_o);
		chk("hazard b", csm_pkg::FWD_EX, fwd_b_o);
		@(negedge clk_i);
		dec_i = '{valid: 1'b1, rd_we: 1'b1, rd: 4'h5, rs1: 4'h3, is_load: 1'b1, default: '0};
		#1;
		chk("hazard mem a", csm_pkg::FWD_MEM, fwd_a_o);
		@(negedge clk_i);
		dec_i = '{valid: 1'b1, rs2: 4'h5, default: '0};
		#1;
		chk("stages", 5'h1f, stage_valid_o);
		chk("load stall", 1, stall_o);
		@(negedge clk_i);
		#1;
		chk("load stall", 0, stall_o);
		chk("hazard mem b", csm_pkg::FWD_MEM, fwd_b_o);
		@(negedge clk_i);
		dec_i = '0;
	endtask

	task automatic dput(input logic [31:0] a, input logic [1:0] s, input logic f);
		@(negedge clk_i);
		dreq_i = 1'b1;
		daddr_i = a;
		dsize_i = s;
		#1;
		chk("align fault", f, align_fault_o);
	endtask

	task automatic t_data();
		do_reset();
		d_wait = 2'h2;
		dput(32'h00000102, csm_pkg::SIZE_WORD, 1'b1);
		dput(32'h00000101, csm_pkg::SIZE_HALF, 1'b1);
		dput(32'h00000100, 2'h3, 1'b1);
		@(negedge clk_i);
		dreq_i = 1'b0;
		chk("dahb req", 0, dahb_req_o);
		dput(32'h00000103, csm_pkg::SIZE_BYTE, 1'b0);
		@(negedge clk_i);
		dreq_i = 1'b0;
		chk("dahb addr", 32'h00000103, dahb_addr_o);
		chk("dahb size", csm_pkg::SIZE_BYTE, dahb_size_o);
		@(negedge clk_i);
		chk("dahb hold", 1, dahb_req_o);
		chk("dahb addr", 32'h00000103, dahb_addr_o);
		n = 0;
		while (dahb_ready_i !== 1'b1) begin
			@(negedge clk_i);
			n++;
			if (n > 8) begin
				$display("Error dahb ready expected 1 seen 0");
				error_cnt++;
				finish_test();
			end
		end
		@(negedge clk_i);
		chk("dahb req", 0, dahb_req_o);
	endtask

	initial begin
		nrst_i = 1'b0;
		dec_i = '0;
		d = '0;
		exc_i = '0;
		branch_tgt_i = 32'h0;
		dreq_i = 1'b0;
		daddr_i = 32'h0;
		dsize_i = 2'h0;
		d_wait = 2'h0;
		error_cnt = 0;
		checks = 0;
		t_reset();
		t_bytecode();
		t_compact();
		t_mode();
		t_hazard();
		t_data();
		exc_case(7'h40, csm_pkg::MODE_ABT, csm_pkg::VEC_DABT);
		exc_case(7'h08, csm_pkg::MODE_ABT, csm_pkg::VEC_PABT);
		exc_case(7'h04, csm_pkg::MODE_ABT, csm_pkg::VEC_PABT);
		exc_case(7'h02, csm_pkg::MODE_UND, csm_pkg::VEC_UND);
		exc_case(7'h01, csm_pkg::MODE_SVC, csm_pkg::VEC_SWI);
		exc_case(7'h70, csm_pkg::MODE_ABT, csm_pkg::VEC_DABT);
		exc_case(7'h30, csm_pkg::MODE_FIQ, csm_pkg::VEC_FIQ);
		exc_case(7'h18, csm_pkg::MODE_IRQ, csm_pkg::VEC_IRQ);
		exc_case(7'h09, csm_pkg::MODE_ABT, csm_pkg::VEC_PABT);
		finish_test();
	end
endmodule
